// File: src/ggr_pkg.sv
// Functional notes
// - Charge and results held as 16-bit byte pairs
// - Limits checked, flagged, alert pin pulled low
// - Charge high limit at 04h/05h, resets FFh
// - Charge low limit at 06h/07h, resets 00h
// - Voltage result 08h-09h, voltage limits 0Ah-0Dh
// - Current result 0Eh-0Fh, current limits 10h-13h
// - Status bit7 reserved, bit0 resets to one
// - Undervoltage sets bit0, halts integration, keeps count
// - Count wrap sets bit5, integration continues
// - Each count step checks charge limits, bits 3/2
// - Each conversion checks limits, bits 1/6/4
// - Status read clears all bits, events in the same cycle win
// - Control register at 01h, resets 3Ch
// - Control bits 7:6 select converter mode
// - Control bits 5:3 select prescale factor
// - Prescaler wrap steps count up or down
// - Scan mode converts all three every 10 s
// - Control bits 2:1 select pin function
// - Charge-complete low loads count FFFFh
package ggr_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS     = 8'h00;
  localparam logic [7:0] ADDR_CONTROL    = 8'h01;
  localparam logic [7:0] ADDR_ACR_HI     = 8'h02;
  localparam logic [7:0] ADDR_ACR_LO     = 8'h03;
  localparam logic [7:0] ADDR_CHG_HI_HI  = 8'h04;
  localparam logic [7:0] ADDR_CHG_HI_LO  = 8'h05;
  localparam logic [7:0] ADDR_CHG_LO_HI  = 8'h06;
  localparam logic [7:0] ADDR_CHG_LO_LO  = 8'h07;
  localparam logic [7:0] ADDR_VOLT_HI    = 8'h08;
  localparam logic [7:0] ADDR_VOLT_LO    = 8'h09;
  localparam logic [7:0] ADDR_VUP_HI     = 8'h0A;
  localparam logic [7:0] ADDR_VUP_LO     = 8'h0B;
  localparam logic [7:0] ADDR_VDN_HI     = 8'h0C;
  localparam logic [7:0] ADDR_VDN_LO     = 8'h0D;
  localparam logic [7:0] ADDR_AMP_HI     = 8'h0E;
  localparam logic [7:0] ADDR_AMP_LO     = 8'h0F;
  localparam logic [7:0] ADDR_AUP_HI     = 8'h10;
  localparam logic [7:0] ADDR_AUP_LO     = 8'h11;
  localparam logic [7:0] ADDR_ADN_HI     = 8'h12;
  localparam logic [7:0] ADDR_ADN_LO     = 8'h13;
  localparam logic [7:0] ADDR_THERM_HI   = 8'h14;
  localparam logic [7:0] ADDR_THERM_LO   = 8'h15;
  localparam logic [7:0] ADDR_TUP        = 8'h16;
  localparam logic [7:0] ADDR_TDN        = 8'h17;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_STATUS  = 8'h01;
  localparam logic [7:0]  RST_CONTROL = 8'h3C;
  localparam logic [15:0] RST_ACR     = 16'h7FFF;
  localparam logic [15:0] RST_UPPER   = 16'hFFFF;
  localparam logic [15:0] RST_LOWER   = 16'h0000;
  localparam logic [15:0] RST_RESULT  = 16'h0000;
  localparam logic [7:0]  RST_T_UPPER = 8'hFF;
  localparam logic [7:0]  RST_T_LOWER = 8'h00;
  localparam logic [15:0] CC_LOAD     = 16'hFFFF;

  // ----------------------------------------------------------------
  // Status bits
  // ----------------------------------------------------------------
  localparam int ST_RSVD   = 7;
  localparam int ST_AMPS   = 6;
  localparam int ST_WRAP   = 5;
  localparam int ST_THERM  = 4;
  localparam int ST_CHG_HI = 3;
  localparam int ST_CHG_LO = 2;
  localparam int ST_VOLTS  = 1;
  localparam int ST_UNDERVOLTAGE_LOCKOUT_FLAG   = 0;
  localparam logic [7:0] ALERT_MASK = 8'h5E;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int CTL_MODE_MSB = 7;
  localparam int CTL_MODE_LSB = 6;
  localparam int CTL_PRE_MSB  = 5;
  localparam int CTL_PRE_LSB  = 3;
  localparam int CTL_PIN_MSB  = 2;
  localparam int CTL_PIN_LSB  = 1;
  localparam logic [1:0] MODE_AUTO   = 2'h3;
  localparam logic [1:0] MODE_SCAN   = 2'h2;
  localparam logic [1:0] MODE_MANUAL = 2'h1;
  localparam logic [1:0] MODE_SLEEP  = 2'h0;
  localparam logic [1:0] PIN_ALERT   = 2'h2;
  localparam logic [1:0] PIN_CC      = 2'h1;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned SCAN_PERIOD_S = 10;
  localparam int unsigned SCAN_CYCLES   = SCAN_PERIOD_S * CLK_HZ;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_VOLTS = 2'h0;
  localparam logic [1:0] SEL_AMPS  = 2'h1;
  localparam logic [1:0] SEL_THERM = 2'h2;

  typedef enum logic [1:0] {
    SEQ_IDLE, SEQ_VOLTS, SEQ_AMPS, SEQ_THERM
  } ggr_seq_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ggr_reg_req_t;

  typedef struct packed {
    logic        done;
    logic [15:0] data;
  } ggr_conv_rsp_t;

endpackage : ggr_pkg

// File: src/ggr_limit_check.sv
`timescale 1ns/100ps
module ggr_limit_check #(
  parameter int W = 16
) (
  // Value and limits
  input  wire logic [W-1:0] value,
  input  wire logic [W-1:0] upper,
  input  wire logic [W-1:0] lower,
  // Violations
  output logic              over,
  output logic              under
);
  assign over  = value > upper;
  assign under = value < lower;
endmodule : ggr_limit_check

// File: src/ggr_gauge_regs.sv
`timescale 1ns/100ps
module ggr_gauge_regs #(
  parameter int unsigned SCAN_CYCLES = ggr_pkg::SCAN_CYCLES
) (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  resetn,
  // Register port from serial front end
  input  ggr_pkg::ggr_reg_req_t      regReq,
  output logic [7:0]                 regRdData,
  // Integrator and supply monitor, asynchronous
  input  wire logic                  intUp,
  input  wire logic                  intDown,
  input  wire logic                  uvDetect,
  // Converter
  output logic                       convReq,
  output logic [1:0]                 convSel,
  input  ggr_pkg::ggr_conv_rsp_t     convRsp,
  // Dual-function pin
  input  wire logic                  pinIn,
  output logic                       pinOut,
  output logic                       pinOe
);
  import ggr_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  status;
    logic [7:0]  control;
    logic [15:0] accumulated_charge_count;
    logic [15:0] chgUp;
    logic [15:0] chgDn;
    logic [15:0] voltRes;
    logic [15:0] voltUp;
    logic [15:0] voltDn;
    logic [15:0] ampRes;
    logic [15:0] ampUp;
    logic [15:0] ampDn;
    logic [15:0] thermRes;
    logic [7:0]  thermUp;
    logic [7:0]  thermDn;
    logic [11:0] pre;
    ggr_seq_t    seq;
    logic [31:0] scanCnt;
    logic        scanDue;
    logic        manualGo;
    logic [3:0]  chk;
    logic [7:0]  rdData;
    logic [1:0]  upSync;
    logic [1:0]  dnSync;
    logic [1:0]  uvSync;
    logic [1:0]  pinSync;
    logic        upPrev;
    logic        dnPrev;
    logic        convReq;
    logic [1:0]  convSel;
    logic        pinDrive;
  } ggr_state_t;

  localparam ggr_state_t RST_STATE = '{
    status:   RST_STATUS,
    control:  RST_CONTROL,
    accumulated_charge_count:      RST_ACR,
    chgUp:    RST_UPPER,
    chgDn:    RST_LOWER,
    voltRes:  RST_RESULT,
    voltUp:   RST_UPPER,
    voltDn:   RST_LOWER,
    ampRes:   RST_RESULT,
    ampUp:    RST_UPPER,
    ampDn:    RST_LOWER,
    thermRes: RST_RESULT,
    thermUp:  RST_T_UPPER,
    thermDn:  RST_T_LOWER,
    seq:      SEQ_IDLE,
    pinSync:  2'b11,
    default:  '0
  };

  localparam logic [31:0] SCAN_LAST = 32'(SCAN_CYCLES - 1);
  localparam int CHK_CHG   = 0;
  localparam int CHK_VOLTS = 1;
  localparam int CHK_AMPS  = 2;
  localparam int CHK_THERM = 3;

  ggr_state_t s_ff;
  ggr_state_t nxt_s;

  // ----------------------------------------------------------------
  // Limit comparators
  // ----------------------------------------------------------------
  logic chgOver;
  logic chgUnder;
  logic voltOver;
  logic voltUnder;
  logic ampOver;
  logic ampUnder;
  logic thermOver;
  logic thermUnder;

  ggr_limit_check #(.W(16)) u_chg (
    .value (s_ff.accumulated_charge_count),
    .upper (s_ff.chgUp),
    .lower (s_ff.chgDn),
    .over  (chgOver),
    .under (chgUnder)
  );
  ggr_limit_check #(.W(16)) u_volt (
    .value (s_ff.voltRes),
    .upper (s_ff.voltUp),
    .lower (s_ff.voltDn),
    .over  (voltOver),
    .under (voltUnder)
  );
  ggr_limit_check #(.W(16)) u_amp (
    .value (s_ff.ampRes),
    .upper (s_ff.ampUp),
    .lower (s_ff.ampDn),
    .over  (ampOver),
    .under (ampUnder)
  );
  ggr_limit_check #(.W(8)) u_therm (
    .value (s_ff.thermRes[15:8]),
    .upper (s_ff.thermUp),
    .lower (s_ff.thermDn),
    .over  (thermOver),
    .under (thermUnder)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0]  sets;
    logic [7:0]  rdv;
    logic [11:0] preLimit;
    logic [1:0]  mode;
    logic        upEv;
    logic        dnEv;
    logic        stepUp;
    logic        stepDn;
    logic        start;
    sets     = '0;
    rdv      = '0;
    preLimit = '0;
    mode     = s_ff.control[CTL_MODE_MSB:CTL_MODE_LSB];
    upEv     = 1'b0;
    dnEv     = 1'b0;
    stepUp   = 1'b0;
    stepDn   = 1'b0;
    start    = 1'b0;
    nxt_s    = s_ff;

    // Input synchronisers and edge detect
    nxt_s.upSync  = {s_ff.upSync[0], intUp};
    nxt_s.dnSync  = {s_ff.dnSync[0], intDown};
    nxt_s.uvSync  = {s_ff.uvSync[0], uvDetect};
    nxt_s.pinSync = {s_ff.pinSync[0], pinIn};
    nxt_s.upPrev  = s_ff.upSync[1];
    nxt_s.dnPrev  = s_ff.dnSync[1];
    upEv = s_ff.upSync[1] & ~s_ff.upPrev & ~s_ff.uvSync[1];
    dnEv = s_ff.dnSync[1] & ~s_ff.dnPrev & ~s_ff.uvSync[1];

    // Prescale limit from factor code
    case (s_ff.control[CTL_PRE_MSB:CTL_PRE_LSB])
      3'h0:    preLimit = 12'h000;
      3'h1:    preLimit = 12'h003;
      3'h2:    preLimit = 12'h00F;
      3'h3:    preLimit = 12'h03F;
      3'h4:    preLimit = 12'h0FF;
      3'h5:    preLimit = 12'h3FF;
      default: preLimit = 12'hFFF;
    endcase

    // Prescaler and charge count
    if (upEv && !dnEv) begin
      if (s_ff.pre >= preLimit) begin
        nxt_s.pre = '0;
        stepUp    = 1'b1;
      end else begin
        nxt_s.pre = s_ff.pre + 12'h001;
      end
    end else if (dnEv && !upEv) begin
      if (s_ff.pre == 12'h000 || s_ff.pre > preLimit) begin
        nxt_s.pre = preLimit;
        stepDn    = 1'b1;
      end else begin
        nxt_s.pre = s_ff.pre - 12'h001;
      end
    end
    if (stepUp) begin
      nxt_s.accumulated_charge_count = s_ff.accumulated_charge_count + 16'h0001;
      if (s_ff.accumulated_charge_count == 16'hFFFF) sets[ST_WRAP] = 1'b1;
    end
    if (stepDn) begin
      nxt_s.accumulated_charge_count = s_ff.accumulated_charge_count - 16'h0001;
      if (s_ff.accumulated_charge_count == 16'h0000) sets[ST_WRAP] = 1'b1;
    end
    if (s_ff.control[CTL_PIN_MSB:CTL_PIN_LSB] == PIN_CC &&
        !s_ff.pinSync[1]) begin
      nxt_s.accumulated_charge_count = CC_LOAD;
    end

    // Limit checks one cycle after each update
    nxt_s.chk = '0;
    nxt_s.chk[CHK_CHG] = upEv ^ dnEv;
    if (s_ff.chk[CHK_CHG]) begin
      sets[ST_CHG_HI] = chgOver;
      sets[ST_CHG_LO] = chgUnder;
    end
    if (s_ff.chk[CHK_VOLTS]) sets[ST_VOLTS] = voltOver | voltUnder;
    if (s_ff.chk[CHK_AMPS])  sets[ST_AMPS]  = ampOver | ampUnder;
    if (s_ff.chk[CHK_THERM]) sets[ST_THERM] = thermOver | thermUnder;
    if (s_ff.uvSync[1]) sets[ST_UNDERVOLTAGE_LOCKOUT_FLAG] = 1'b1;

    // Conversion sequencer
    case (s_ff.seq)
      SEQ_IDLE: begin
        start = (mode == MODE_AUTO) ||
                (mode == MODE_SCAN && s_ff.scanDue) ||
                (mode == MODE_MANUAL && s_ff.manualGo);
        if (start) begin
          nxt_s.seq      = SEQ_VOLTS;
          nxt_s.scanDue  = 1'b0;
          nxt_s.manualGo = 1'b0;
        end
      end
      SEQ_VOLTS: begin
        if (convRsp.done) begin
          nxt_s.voltRes        = convRsp.data;
          nxt_s.chk[CHK_VOLTS] = 1'b1;
          nxt_s.seq            = SEQ_AMPS;
        end
      end
      SEQ_AMPS: begin
        if (convRsp.done) begin
          nxt_s.ampRes        = convRsp.data;
          nxt_s.chk[CHK_AMPS] = 1'b1;
          nxt_s.seq           = SEQ_THERM;
        end
      end
      SEQ_THERM: begin
        if (convRsp.done) begin
          nxt_s.thermRes       = convRsp.data;
          nxt_s.chk[CHK_THERM] = 1'b1;
          nxt_s.seq            = SEQ_IDLE;
        end
      end
      default: nxt_s.seq = SEQ_IDLE;
    endcase
    if (mode == MODE_SLEEP) begin
      nxt_s.seq = SEQ_IDLE;
    end

    // Scan period timer
    if (mode == MODE_SCAN) begin
      if (s_ff.scanCnt >= SCAN_LAST) begin
        nxt_s.scanCnt = '0;
        nxt_s.scanDue = 1'b1;
      end else begin
        nxt_s.scanCnt = s_ff.scanCnt + 32'h0000_0001;
      end
    end else begin
      nxt_s.scanCnt = '0;
      nxt_s.scanDue = 1'b0;
    end

    // Host writes
    if (regReq.wr) begin
      case (regReq.addr)
        ADDR_CONTROL: begin
          nxt_s.control = regReq.wdata;
          if (regReq.wdata[CTL_MODE_MSB:CTL_MODE_LSB] == MODE_MANUAL)
            nxt_s.manualGo = 1'b1;
        end
        ADDR_ACR_HI:    nxt_s.accumulated_charge_count[15:8]     = regReq.wdata;
        ADDR_ACR_LO:    nxt_s.accumulated_charge_count[7:0]      = regReq.wdata;
        ADDR_CHG_HI_HI: nxt_s.chgUp[15:8]   = regReq.wdata;
        ADDR_CHG_HI_LO: nxt_s.chgUp[7:0]    = regReq.wdata;
        ADDR_CHG_LO_HI: nxt_s.chgDn[15:8]   = regReq.wdata;
        ADDR_CHG_LO_LO: nxt_s.chgDn[7:0]    = regReq.wdata;
        ADDR_VUP_HI:    nxt_s.voltUp[15:8]  = regReq.wdata;
        ADDR_VUP_LO:    nxt_s.voltUp[7:0]   = regReq.wdata;
        ADDR_VDN_HI:    nxt_s.voltDn[15:8]  = regReq.wdata;
        ADDR_VDN_LO:    nxt_s.voltDn[7:0]   = regReq.wdata;
        ADDR_AUP_HI:    nxt_s.ampUp[15:8]   = regReq.wdata;
        ADDR_AUP_LO:    nxt_s.ampUp[7:0]    = regReq.wdata;
        ADDR_ADN_HI:    nxt_s.ampDn[15:8]   = regReq.wdata;
        ADDR_ADN_LO:    nxt_s.ampDn[7:0]    = regReq.wdata;
        ADDR_TUP:       nxt_s.thermUp       = regReq.wdata;
        ADDR_TDN:       nxt_s.thermDn       = regReq.wdata;
        default: ;
      endcase
    end

    // Host reads
    case (regReq.addr)
      ADDR_STATUS:    rdv = s_ff.status;
      ADDR_CONTROL:   rdv = s_ff.control;
      ADDR_ACR_HI:    rdv = s_ff.accumulated_charge_count[15:8];
      ADDR_ACR_LO:    rdv = s_ff.accumulated_charge_count[7:0];
      ADDR_CHG_HI_HI: rdv = s_ff.chgUp[15:8];
      ADDR_CHG_HI_LO: rdv = s_ff.chgUp[7:0];
      ADDR_CHG_LO_HI: rdv = s_ff.chgDn[15:8];
      ADDR_CHG_LO_LO: rdv = s_ff.chgDn[7:0];
      ADDR_VOLT_HI:   rdv = s_ff.voltRes[15:8];
      ADDR_VOLT_LO:   rdv = s_ff.voltRes[7:0];
      ADDR_VUP_HI:    rdv = s_ff.voltUp[15:8];
      ADDR_VUP_LO:    rdv = s_ff.voltUp[7:0];
      ADDR_VDN_HI:    rdv = s_ff.voltDn[15:8];
      ADDR_VDN_LO:    rdv = s_ff.voltDn[7:0];
      ADDR_AMP_HI:    rdv = s_ff.ampRes[15:8];
      ADDR_AMP_LO:    rdv = s_ff.ampRes[7:0];
      ADDR_AUP_HI:    rdv = s_ff.ampUp[15:8];
      ADDR_AUP_LO:    rdv = s_ff.ampUp[7:0];
      ADDR_ADN_HI:    rdv = s_ff.ampDn[15:8];
      ADDR_ADN_LO:    rdv = s_ff.ampDn[7:0];
      ADDR_THERM_HI:  rdv = s_ff.thermRes[15:8];
      ADDR_THERM_LO:  rdv = s_ff.thermRes[7:0];
      ADDR_TUP:       rdv = s_ff.thermUp;
      ADDR_TDN:       rdv = s_ff.thermDn;
      default:        rdv = 8'h00;
    endcase
    if (regReq.rd) nxt_s.rdData = rdv;

    // Status: read clears, new events win
    if (regReq.rd && regReq.addr == ADDR_STATUS) begin
      nxt_s.status = sets;
    end else begin
      nxt_s.status = s_ff.status | sets;
    end
    nxt_s.status[ST_RSVD] = 1'b0;

    // Outputs
    nxt_s.convReq = (nxt_s.seq != SEQ_IDLE);
    case (nxt_s.seq)
      SEQ_AMPS:  nxt_s.convSel = SEL_AMPS;
      SEQ_THERM: nxt_s.convSel = SEL_THERM;
      default:   nxt_s.convSel = SEL_VOLTS;
    endcase
    nxt_s.pinDrive =
      (nxt_s.control[CTL_PIN_MSB:CTL_PIN_LSB] == PIN_ALERT) &&
      ((nxt_s.status & ALERT_MASK) != 8'h00);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_ff <= RST_STATE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign regRdData = s_ff.rdData;
  assign convReq   = s_ff.convReq;
  assign convSel   = s_ff.convSel;
  assign pinOut    = 1'b0;
  assign pinOe     = s_ff.pinDrive;

endmodule : ggr_gauge_regs

// File: testbench/ggr_checker.sv
`timescale 1ns/100ps
module ggr_checker #(
  parameter int unsigned SCAN_CYCLES = 50
) (
  // Clock and reset
  input wire logic            mclk,
  input wire logic            resetn,
  // Register port
  input ggr_pkg::ggr_reg_req_t  regReq,
  input wire logic [7:0]      regRdData,
  // Integrator and supply
  input wire logic            intUp,
  input wire logic            intDown,
  input wire logic            uvDetect,
  // Converter
  input wire logic            convReq,
  input wire logic [1:0]      convSel,
  input ggr_pkg::ggr_conv_rsp_t convRsp,
  // Pin
  input wire logic            pinIn,
  input wire logic            pinOut,
  input wire logic            pinOe
);
  import ggr_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // --------
  // Scan idle tracker
  // --------
  logic [1:0]  modeSeen_ff;
  logic [31:0] idleCnt_ff;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      modeSeen_ff <= MODE_SLEEP;
      idleCnt_ff  <= '0;
    end else begin
      if (regReq.wr && regReq.addr == ADDR_CONTROL) begin
        modeSeen_ff <= regReq.wdata[7:6];
      end
      if (convReq || modeSeen_ff != MODE_SCAN ||
          (regReq.wr && regReq.addr == ADDR_CONTROL)) begin
        idleCnt_ff <= '0;
      end else begin
        idleCnt_ff <= idleCnt_ff + 32'h1;
      end
    end
  end
  // --------
  // Assertions
  // --------
  a_pin_out_low: assert property (pinOut == 1'b0)
    else $error("pin output not low");
  a_unmapped_zero: assert property (regReq.rd && regReq.addr > ADDR_TDN
    |=> regRdData == 8'h00) else $error("unmapped read not zero");
  a_read_holds: assert property (!regReq.rd |=> $stable(regRdData))
    else $error("read data moved without read");
  a_volt_then_amps: assert property (convReq && convRsp.done
    && convSel == SEL_VOLTS && !regReq.wr |=> convSel == SEL_AMPS)
    else $error("current not converted after voltage");
  a_scan_restarts: assert property ((idleCnt_ff <= SCAN_CYCLES + 32'h3))
    else $error("scan sequence not started in time");
  a_seq_ends: assert property (convReq && convRsp.done
    && convSel == SEL_THERM |=> !convReq)
    else $error("sequence not ended after temperature");
  a_req_holds: assert property (convReq && !convRsp.done && !regReq.wr
    |=> convReq && $stable(convSel)) else $error("request dropped early");
  a_manual_starts: assert property (regReq.wr && regReq.addr == ADDR_CONTROL
    && regReq.wdata[7:6] == MODE_MANUAL && !convReq
    |-> ##2 convReq && convSel == SEL_VOLTS) else $error("manual not started");
  a_sleep_stops: assert property (regReq.wr && regReq.addr == ADDR_CONTROL
    && regReq.wdata[7:6] == MODE_SLEEP |-> ##2 !convReq)
    else $error("sleep did not stop converter");
  a_pin_released: assert property (regReq.wr && regReq.addr == ADDR_CONTROL
    && regReq.wdata[2:1] != PIN_ALERT |-> ##3 !pinOe)
    else $error("pin driven outside alert mode");
  c_seq_done: cover property (convReq && convRsp.done && convSel == SEL_THERM);
  c_alert: cover property ($rose(pinOe));
  c_status_rd: cover property (regReq.rd && regReq.addr == ADDR_STATUS);
endmodule : ggr_checker

bind ggr_gauge_regs ggr_checker #(.SCAN_CYCLES(SCAN_CYCLES)) i_ggr_checker (
  .mclk(mclk), .resetn(resetn), .regReq(regReq), .regRdData(regRdData),
  .intUp(intUp), .intDown(intDown), .uvDetect(uvDetect), .convReq(convReq),
  .convSel(convSel), .convRsp(convRsp), .pinIn(pinIn), .pinOut(pinOut),
  .pinOe(pinOe));

// File: testbench/ggr_host_model.sv
`timescale 1ns/100ps
module ggr_host_model (
  // Clock
  input wire logic            mclk,
  // Register port
  output ggr_pkg::ggr_reg_req_t regReq,
  input wire logic [7:0]      regRdData,
  // Converter
  input wire logic            convReq,
  input wire logic [1:0]      convSel,
  output ggr_pkg::ggr_conv_rsp_t convRsp,
  input wire logic [3:0]      lag
);
  import ggr_pkg::*;
  localparam logic [15:0] RES [3] = '{16'h2345, 16'h0111, 16'h0500};
  logic [3:0] waitCnt;
  initial begin
    regReq = '0;
    convRsp = '0;
    waitCnt = '0;
  end
  // Byte write, released with inverted data
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    regReq = '{1'b1, 1'b0, a, d};
    @(negedge mclk);
    regReq = '{1'b0, 1'b0, ~a, ~d};
  endtask : wr8
  task automatic rd8(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    regReq = '{1'b0, 1'b1, a, 8'h00};
    @(negedge mclk);
    regReq = '{1'b0, 1'b0, ~a, 8'h00};
    d = regRdData;
  endtask : rd8
  // Converter answers after lag cycles, idle data toggles
  always @(negedge mclk) begin
    if (convRsp.done || !convReq) begin
      convRsp <= '{1'b0, ~convRsp.data};
      waitCnt <= '0;
    end else if (waitCnt >= lag) begin
      convRsp <= '{1'b1, RES[convSel]};
    end else begin
      waitCnt <= waitCnt + 4'h1;
    end
  end
endmodule : ggr_host_model

// File: testbench/gas_gauge_register_alert_bank_tb.sv
`timescale 1ns/100ps
module gas_gauge_register_alert_bank_tb;
  import ggr_pkg::*;
  logic mclk, resetn, intUp, intDown, uvDetect, pinIn;
  logic convReq, pinOut, pinOe, seen;
  ggr_reg_req_t regReq;
  ggr_conv_rsp_t convRsp;
  logic [7:0] regRdData;
  logic [1:0] convSel;
  logic [3:0] lag;
  int err_total, checks_done;
  localparam logic [7:0] RST [24] = '{8'h01, 8'h3C, 8'h7F, 8'hFF, 8'hFF,
    8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00,
    8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00};
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  ggr_gauge_regs #(.SCAN_CYCLES(50)) i_ggr_gauge_regs (.mclk(mclk),
    .resetn(resetn), .regReq(regReq), .regRdData(regRdData), .intUp(intUp),
    .intDown(intDown), .uvDetect(uvDetect), .convReq(convReq),
    .convSel(convSel), .convRsp(convRsp), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe(pinOe));
  ggr_host_model i_ggr_host_model (.mclk(mclk), .regReq(regReq),
    .regRdData(regRdData), .convReq(convReq), .convSel(convSel),
    .convRsp(convRsp), .lag(lag));
  // --------
  // Helpers
  // --------
  task automatic chk8(input string n, input logic [7:0] e,
                      input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk8
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_ggr_host_model.wr8(a, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    i_ggr_host_model.rd8(a, v);
    chk8($sformatf("reg %h", a), e, v);
  endtask : rdc
  task automatic bump(input int n, input logic dn);
    repeat (n) begin
      @(negedge mclk);
      if (dn) intDown = 1'b1;
      else intUp = 1'b1;
      repeat (2) @(negedge mclk);
      intUp = 1'b0;
      intDown = 1'b0;
      repeat (4) @(negedge mclk);
    end
  endtask : bump
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out
  // --------
  // Scenarios
  // --------
  task automatic t_regs;
    for (int a = 0; a < 24; a++) rdc(a[7:0], RST[a]);
    rdc(ADDR_STATUS, 8'h00);
    rdc(8'h18, 8'h00);
    for (int a = 2; a < 24; a++) begin
      wr(a[7:0], 8'h5A);
      rdc(a[7:0], (a inside {8, 9, 14, 15, 20, 21}) ? RST[a] : 8'h5A);
      wr(a[7:0], RST[a]);
    end
    wr(ADDR_CONTROL, 8'h1A);
    rdc(ADDR_CONTROL, 8'h1A);
    wr(ADDR_STATUS, 8'hFF);
    rdc(ADDR_STATUS, 8'h00);
    $display("register test done");
  endtask : t_regs
  task automatic t_conv;
    wr(ADDR_VUP_HI, 8'h10);
    wr(ADDR_ADN_HI, 8'h02);
    wr(ADDR_TDN, 8'h06);
    wr(ADDR_CONTROL, 8'h44);
    for (int i = 0; i < 60 && pinOe !== 1'b1; i++) @(negedge mclk);
    chk8("alert pin", 8'h01, {7'h0, pinOe});
    rdc(ADDR_VOLT_HI, 8'h23);
    rdc(ADDR_VOLT_LO, 8'h45);
    rdc(ADDR_AMP_LO, 8'h11);
    rdc(ADDR_THERM_HI, 8'h05);
    rdc(ADDR_STATUS, 8'h52);
    repeat (3) @(negedge mclk);
    chk8("alert release", 8'h00, {7'h0, pinOe});
    $display("conversion test done");
  endtask : t_conv
  task automatic t_modes;
    lag = 4'h9;
    for (int m = 3; m >= 0; m--) begin
      if (m != 1) begin
        wr(ADDR_CONTROL, {m[1:0], 6'h04});
        repeat (3) @(negedge mclk);
        seen = 1'b0;
        repeat (80) begin
          @(negedge mclk);
          seen |= convReq;
        end
        chk8("converter busy", {7'h0, m != 0}, {7'h0, seen});
      end
    end
    lag = 4'h0;
    $display("mode test done");
  endtask : t_modes
  task automatic t_count;
    logic [7:0] v;
    wr(ADDR_ACR_HI, 8'hFF);
    wr(ADDR_ACR_LO, 8'hFF);
    i_ggr_host_model.rd8(ADDR_STATUS, v);
    bump(1, 1'b0);
    chk8("alert pin", 8'h00, {7'h0, pinOe});
    rdc(ADDR_ACR_HI, 8'h00);
    rdc(ADDR_STATUS, 8'h20);
    wr(ADDR_CHG_LO_LO, 8'h05);
    bump(1, 1'b0);
    rdc(ADDR_STATUS, 8'h04);
    wr(ADDR_CHG_HI_HI, 8'h00);
    wr(ADDR_CHG_HI_LO, 8'h00);
    bump(2, 1'b0);
    bump(1, 1'b1);
    rdc(ADDR_ACR_LO, 8'h02);
    rdc(ADDR_STATUS, 8'h0C);
    uvDetect = 1'b1;
    repeat (3) @(negedge mclk);
    bump(1, 1'b0);
    rdc(ADDR_ACR_LO, 8'h02);
    rdc(ADDR_STATUS, 8'h01);
    uvDetect = 1'b0;
    repeat (3) @(negedge mclk);
    bump(1, 1'b0);
    rdc(ADDR_ACR_LO, 8'h03);
    for (int c = 0; c < 6; c++) begin
      wr(ADDR_CONTROL, {2'b00, c[2:0], 3'b100});
      wr(ADDR_ACR_LO, 8'h10);
      bump((1 << (2 * c)) - 1, 1'b0);
      rdc(ADDR_ACR_LO, 8'h10);
      bump(1, 1'b0);
      rdc(ADDR_ACR_LO, 8'h11);
    end
    $display("count test done");
  endtask : t_count
  task automatic t_cc;
    wr(ADDR_CONTROL, 8'h02);
    wr(ADDR_ACR_HI, 8'h12);
    pinIn = 1'b0;
    repeat (5) @(negedge mclk);
    chk8("pin drive", 8'h00, {7'h0, pinOe});
    pinIn = 1'b1;
    rdc(ADDR_ACR_HI, 8'hFF);
    rdc(ADDR_ACR_LO, 8'hFF);
    $display("charge complete test done");
  endtask : t_cc
  initial begin
    repeat (40000) @(posedge mclk);
    err_total++;
    close_out;
  end
  initial begin
    resetn = 1'b0;
    intUp = 1'b0;
    intDown = 1'b0;
    uvDetect = 1'b0;
    pinIn = 1'b1;
    lag = 4'h0;
    err_total = 0;
    checks_done = 0;
    repeat (3) @(negedge mclk);
    resetn = 1'b1;
    t_regs;
    t_conv;
    t_modes;
    t_count;
    t_cc;
    close_out;
  end
endmodule : gas_gauge_register_alert_bank_tb
